// ===== verilog/lpgc_pkg.sv
package lpgc_pkg;
  localparam int NCH = 16;
  localparam int NGRP = 4;
  localparam int CLK_MHZ = 250;
  localparam int OSC_MHZ = 8;
  localparam int STEP_UNIT_US = 500;
  localparam int HALF_MS_TICKS = OSC_MHZ * STEP_UNIT_US;
  localparam int HMS_PER_S = 1000000 / STEP_UNIT_US;
  localparam int BLINK_DIV_LOG2 = 3;
  localparam int LONG_STEP_LOG2 = 5;
  localparam int QUINARY = 5;

  localparam logic [7:0] R_MODE = 8'h00;
  localparam logic [7:0] R_STAT = 8'h01;
  localparam logic [7:0] R_GRP = 8'h02;
  localparam logic [7:0] R_FRQ = 8'h03;
  localparam logic [7:0] R_SEL = 8'h04;
  localparam logic [7:0] R_DLY = 8'h08;
  localparam logic [7:0] R_GCTL = 8'h09;
  localparam logic [7:0] R_GEN = 8'h0A;
  localparam logic [7:0] R_GSEL = 8'h0C;
  localparam logic [7:0] R_GCFG = 8'h10;
  localparam logic [7:0] R_PWM = 8'h20;
  localparam logic [7:0] R_IREF = 8'h30;
  localparam logic [7:0] R_ADDR = 8'h40;
  localparam logic [7:0] R_EOPN = 8'h44;
  localparam logic [7:0] R_ESHT = 8'h46;

  localparam int M_ACK = 0;
  localparam int M_BLINK = 1;
  localparam int M_EXP = 2;
  localparam int M_CLR = 3;
  localparam int M_EN = 4;
  localparam int GC_CONT = 4;
  localparam int G_RATE = 0;
  localparam int G_STEP = 1;
  localparam int G_HOLD = 2;
  localparam int G_FINAL = 3;
  localparam int RATE_UP_EN = 7;
  localparam int RATE_DN_EN = 6;
  localparam int STEP_LONG = 5;
  localparam int HOLD_ON_EN = 7;
  localparam int HOLD_OFF_EN = 6;

  localparam logic [7:0] MODE_RST = 8'h30;
  localparam logic [7:0] GRP_RST = 8'hFF;
  localparam logic [7:0] PWM_FULL = 8'hFF;
  localparam logic [6:0] ADDR_GRP_RST = 7'h60;
  localparam logic [6:0] ADDR_SUB2_RST = 7'h62;
  localparam logic [6:0] ADDR_SUB3_RST = 7'h63;
  localparam logic [2:0] STRAP_SETTLE = 3'h7;

  typedef enum logic [1:0] {
    LS_OFF = 2'h0, LS_ON = 2'h1, LS_IND = 2'h2, LS_IGRP = 2'h3
  } lpgc_ledsel_type;

  typedef enum logic [4:0] {
    GS_IDLE = 5'h01, GS_UP = 5'h02, GS_HON = 5'h04,
    GS_DOWN = 5'h08, GS_HOFF = 5'h10
  } lpgc_gst_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpgc_bus_type;

  typedef struct packed {
    logic [2:0] ad2;
    logic [2:0] ad1;
    logic [2:0] ad0;
    logic [NCH-1:0] short_l;
    logic [NCH-1:0] open_l;
    logic otp;
    logic oe_n;
  } lpgc_pins_type;

  typedef struct packed {
    lpgc_pins_type [2:0] sy;
    lpgc_pins_type flt;
    logic [2:0] strap_cnt;
    logic [6:0] own;
    logic [7:0] mode, grp_sh, grp_act, frq_sh, frq_act, gctl;
    logic [3:0] dly;
    lpgc_ledsel_type [NCH-1:0] sel_sh, sel_act;
    logic [NCH-1:0][7:0] pwm_sh, pwm_act, ir_sh, ir_act;
    logic [NCH-1:0] gen;
    logic [NCH-1:0][1:0] gsel;
    logic [NGRP-1:0][3:0][7:0] gcfg;
    logic [3:0][6:0] addr;
    logic [NCH-1:0] e_open, e_short;
    logic [8:0] acc;
    logic [7:0] pcnt, gcnt;
    logic [10:0] gpre;
    logic [15:0] hms;
    lpgc_gst_type [NGRP-1:0] gst;
    logic [NGRP-1:0][7:0] glvl;
    logic [NGRP-1:0][13:0] gtmr;
    logic [NCH-1:0] led;
    logic [NCH-1:0][7:0] iref;
    logic [7:0] rdata;
  } lpgc_state_type;

  // Hold codes: quarter seconds up to 1 s, then 2, 4 and 6 s
  function automatic logic [13:0] lpgc_hold_hms(logic [2:0] v);
    if (v <= 3'h4) begin
      return 14'(int'(v) * HMS_PER_S / 4);
    end
    return 14'((int'(v) - 4) * 2 * HMS_PER_S);
  endfunction : lpgc_hold_hms
endpackage : lpgc_pkg

// ===== verilog/lpgc_core.sv
// Operation
// - Each channel has an 8-bit PWM at 31.25 kHz, off to fully on.
// - One 8-bit group PWM: 122 Hz dimming or 15 Hz to 16.8 s blinking.
// - Each output selects off, on, own PWM, or own plus group PWM.
// - Per-channel 8-bit code sets the output peak current linearly.
// - Four gradation groups with rate, step, hold and final current.
// - Each group plays its pattern once or repeats it continuously.
// - Each channel is normal or gradation, assigned to one of four groups.
// - Step time is a 6-bit code from 0.5 ms to 512 ms.
// - Hold-on and hold-off times are 3-bit codes from 0 s to 6 s.
// - Gradation brightness follows a linear or exponential curve.
// - Ramp-up and ramp-down are enabled separately per group.
// - Output settings apply on acknowledge or on STOP; STOP is default.
// - Active-low output gate input switches all outputs together.
// - Software reset call resets everything as at power-on.
// - Group and three sub-call addresses, each enabled, answered as own.
// - One sub-call address defaults to a channel-width identifying value.
// - Three five-level straps select one of 125 slave addresses.
// - Open and short errors are recorded and readable; overtemperature reads as live status.
// - Over the temperature limit the outputs shut down.
// - Programmable per-output turn-on delay staggers channel switching.
// - Reset sets channel brightness off and group brightness maximum.
// - All timing derives from an internal 8 MHz time base.
// - Straps are sampled once after reset, then fixed.
module lpgc_core
  import lpgc_pkg::*;
#(
  parameter int HMS_TICKS = HALF_MS_TICKS,
  parameter logic [6:0] ADDR_BASE = 7'h01,
  // Arbitrary value, identifies a 16-wide part
  parameter logic [6:0] SUB1_RST = 7'h61
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire lpgc_bus_type bus_i,
  output logic [7:0] rd_data_o,
  // Serial front end events
  input wire logic bus_ack_i,
  input wire logic bus_stop_i,
  input wire logic soft_reset_call_i,
  input wire logic [6:0] rx_addr_i,
  output logic addr_hit_o,
  // Pins and sensors
  input wire logic oe_n_i,
  input wire logic [2:0] addr_strap_0_i,
  input wire logic [2:0] addr_strap_1_i,
  input wire logic [2:0] addr_strap_2_i,
  input wire logic [NCH-1:0] open_i,
  input wire logic [NCH-1:0] short_i,
  input wire logic overtemp_i,
  // Channel drive
  output logic [NCH-1:0] led_on_o,
  output logic [NCH-1:0][7:0] led_iref_o,
  output logic tsd_o
);

  function automatic lpgc_state_type rst_state();
    lpgc_state_type r;
    r = '0;
    r.mode = MODE_RST;
    r.grp_sh = GRP_RST;
    r.grp_act = GRP_RST;
    r.flt.oe_n = 1'b1;
    r.addr[0] = ADDR_GRP_RST;
    r.addr[1] = SUB1_RST;
    r.addr[2] = ADDR_SUB2_RST;
    r.addr[3] = ADDR_SUB3_RST;
    for (int g = 0; g < NGRP; g++) begin
      r.gst[g] = GS_IDLE;
    end
    return r;
  endfunction : rst_state

  localparam lpgc_state_type RST_S = rst_state();

  function automatic logic [7:0] rd_mux(lpgc_state_type s, logic [7:0] a);
    logic [7:0] r;
    r = '0;
    if (a == R_MODE) begin
      r = s.mode;
    end else if (a == R_STAT) begin
      r = {5'h00, |s.e_short, |s.e_open, s.flt.otp};
    end else if (a == R_GRP) begin
      r = s.grp_sh;
    end else if (a == R_FRQ) begin
      r = s.frq_sh;
    end else if (a[7:2] == R_SEL[7:2]) begin
      for (int k = 0; k < 4; k++) begin
        r[2*k +: 2] = s.sel_sh[{a[1:0], 2'(k)}];
      end
    end else if (a == R_DLY) begin
      r = {4'h0, s.dly};
    end else if (a == R_GCTL) begin
      r = s.gctl;
    end else if (a[7:1] == R_GEN[7:1]) begin
      r = s.gen[{a[0], 3'h0} +: 8];
    end else if (a[7:2] == R_GSEL[7:2]) begin
      for (int k = 0; k < 4; k++) begin
        r[2*k +: 2] = s.gsel[{a[1:0], 2'(k)}];
      end
    end else if (a[7:4] == R_GCFG[7:4]) begin
      r = s.gcfg[a[3:2]][a[1:0]];
    end else if (a[7:4] == R_PWM[7:4]) begin
      r = s.pwm_sh[a[3:0]];
    end else if (a[7:4] == R_IREF[7:4]) begin
      r = s.ir_sh[a[3:0]];
    end else if (a[7:2] == R_ADDR[7:2]) begin
      r = {1'b0, s.addr[a[1:0]]};
    end else if (a[7:1] == R_EOPN[7:1]) begin
      r = s.e_open[{a[0], 3'h0} +: 8];
    end else if (a[7:1] == R_ESHT[7:1]) begin
      r = s.e_short[{a[0], 3'h0} +: 8];
    end
    return r;
  endfunction : rd_mux

  lpgc_state_type s, n;
  lpgc_pins_type pins;
  logic tick, wrap, hmsp, grp_on, ind, on, clr, commit, restart;
  logic [8:0] acc, inc, stp;
  logic [10:0] gdiv;
  logic [7:0] ph, lvl, a, w;
  logic [15:0] sq;
  logic [13:0] stepu, hon, hoff;
  logic [3:0][7:0] cf;

  assign pins = '{ad2: addr_strap_2_i, ad1: addr_strap_1_i,
                  ad0: addr_strap_0_i, short_l: short_i, open_l: open_i,
                  otp: overtemp_i, oe_n: oe_n_i};

  always_comb begin
    n = s;
    tick = 1'b0;
    wrap = 1'b0;
    hmsp = 1'b0;
    grp_on = 1'b0;
    ind = 1'b0;
    on = 1'b0;
    restart = 1'b0;
    acc = '0;
    inc = '0;
    stp = '0;
    gdiv = '0;
    ph = '0;
    lvl = '0;
    sq = '0;
    stepu = '0;
    hon = '0;
    hoff = '0;
    cf = '0;
    a = bus_i.addr;
    w = bus_i.wdata;
    clr = bus_i.wr && a == R_MODE && w[M_CLR];

    // Three-stage sampling; a change counts when stages two and three agree
    n.sy[0] = pins;
    n.sy[1] = s.sy[0];
    n.sy[2] = s.sy[1];
    n.flt = lpgc_pins_type'((s.sy[1] & s.sy[2])
                            | (s.flt & (s.sy[1] | s.sy[2])));

    if (s.strap_cnt != STRAP_SETTLE) begin
      n.strap_cnt = s.strap_cnt + 3'h1;
    end
    if (s.strap_cnt == STRAP_SETTLE - 3'h1) begin
      n.own = 7'(int'(ADDR_BASE) + QUINARY * QUINARY * int'(s.flt.ad2)
                 + QUINARY * int'(s.flt.ad1) + int'(s.flt.ad0));
    end

    // Fractional divider: average rate of ticks is exactly 8 MHz
    acc = s.acc + 9'(OSC_MHZ);
    tick = acc >= 9'(CLK_MHZ);
    n.acc = tick ? acc - 9'(CLK_MHZ) : acc;
    if (tick) begin
      n.pcnt = s.pcnt + 8'h01;
      wrap = s.pcnt == PWM_FULL;
      if (s.hms >= 16'(HMS_TICKS - 1)) begin
        n.hms = '0;
        hmsp = 1'b1;
      end else begin
        n.hms = s.hms + 16'h0001;
      end
    end

    // Dimming steps once per PWM frame; blinking 8 * (freq + 1) frames
    gdiv = s.mode[M_BLINK] ? {s.frq_act, {BLINK_DIV_LOG2{1'b1}}} : '0;
    if (wrap) begin
      if (s.gpre >= gdiv) begin
        n.gpre = '0;
        n.gcnt = s.gcnt + 8'h01;
      end else begin
        n.gpre = s.gpre + 11'h001;
      end
    end
    grp_on = s.gcnt < s.grp_act;

    for (int g = 0; g < NGRP; g++) begin
      cf = s.gcfg[g];
      stp = 9'(cf[G_STEP][4:0]) + 9'h001;
      stepu = 14'(stp)
              << (cf[G_STEP][STEP_LONG] ? LONG_STEP_LOG2 : 0);
      hon = cf[G_HOLD][HOLD_ON_EN]
            ? lpgc_hold_hms(cf[G_HOLD][5:3]) : '0;
      hoff = cf[G_HOLD][HOLD_OFF_EN]
             ? lpgc_hold_hms(cf[G_HOLD][2:0]) : '0;
      inc = 9'(cf[G_RATE][5:0]) + 9'h001;
      restart = 1'b0;
      if (!s.gctl[g]) begin
        n.gst[g] = GS_IDLE;
        n.glvl[g] = '0;
        n.gtmr[g] = '0;
      end else if (hmsp) begin
        if (s.gtmr[g] != '0) begin
          n.gtmr[g] = s.gtmr[g] - 14'h0001;
        end else begin
          unique case (s.gst[g])
            GS_IDLE: restart = 1'b1;
            GS_UP: begin
              if (9'(s.glvl[g]) + inc >= 9'(cf[G_FINAL])) begin
                n.glvl[g] = cf[G_FINAL];
                n.gst[g] = GS_HON;
                n.gtmr[g] = hon;
              end else begin
                n.glvl[g] = s.glvl[g] + inc[7:0];
                n.gtmr[g] = stepu - 14'h0001;
              end
            end
            GS_HON: begin
              if (cf[G_RATE][RATE_DN_EN]) begin
                n.gst[g] = GS_DOWN;
                n.gtmr[g] = stepu - 14'h0001;
              end else begin
                n.glvl[g] = '0;
                n.gst[g] = GS_HOFF;
                n.gtmr[g] = hoff;
              end
            end
            GS_DOWN: begin
              if (9'(s.glvl[g]) <= inc) begin
                n.glvl[g] = '0;
                n.gst[g] = GS_HOFF;
                n.gtmr[g] = hoff;
              end else begin
                n.glvl[g] = s.glvl[g] - inc[7:0];
                n.gtmr[g] = stepu - 14'h0001;
              end
            end
            GS_HOFF: begin
              if (s.gctl[GC_CONT + g]) begin
                restart = 1'b1;
              end else begin
                n.gctl[g] = 1'b0;
                n.gst[g] = GS_IDLE;
              end
            end
            default: n.gst[g] = GS_IDLE;
          endcase
        end
      end
      if (restart) begin
        if (cf[G_RATE][RATE_UP_EN]) begin
          n.glvl[g] = '0;
          n.gst[g] = GS_UP;
          n.gtmr[g] = stepu - 14'h0001;
        end else begin
          n.glvl[g] = cf[G_FINAL];
          n.gst[g] = GS_HON;
          n.gtmr[g] = hon;
        end
      end
    end

    for (int ch = 0; ch < NCH; ch++) begin
      // Delay shifts each channel's PWM phase by ch * dly ticks
      ph = s.pcnt - 8'(ch) * {4'h0, s.dly};
      ind = s.pwm_act[ch] == PWM_FULL || ph < s.pwm_act[ch];
      unique case (s.sel_act[ch])
        LS_OFF: on = 1'b0;
        LS_ON: on = 1'b1;
        LS_IND: on = ind;
        LS_IGRP: on = ind & grp_on;
      endcase
      n.led[ch] = on & ~s.flt.oe_n & ~s.flt.otp;
      lvl = s.glvl[s.gsel[ch]];
      sq = 16'(lvl) * 16'(lvl);
      if (s.mode[M_EXP]) begin
        lvl = sq[15:8];
      end
      n.iref[ch] = s.gen[ch] ? lvl : s.ir_act[ch];
    end

    // A fault seen in the same cycle as a clear is kept
    n.e_open = (s.e_open & ~{NCH{clr}})
               | (s.flt.open_l & s.led);
    n.e_short = (s.e_short & ~{NCH{clr}})
                | (s.flt.short_l & s.led);

    // Software writes last, so a written start bit beats an end-of-run clear
    if (bus_i.wr) begin
      if (a == R_MODE) begin
        n.mode = w & ~(8'h01 << M_CLR);
      end else if (a == R_GRP) begin
        n.grp_sh = w;
      end else if (a == R_FRQ) begin
        n.frq_sh = w;
      end else if (a[7:2] == R_SEL[7:2]) begin
        for (int k = 0; k < 4; k++) begin
          n.sel_sh[{a[1:0], 2'(k)}] = lpgc_ledsel_type'(w[2*k +: 2]);
        end
      end else if (a == R_DLY) begin
        n.dly = w[3:0];
      end else if (a == R_GCTL) begin
        n.gctl = w;
      end else if (a[7:1] == R_GEN[7:1]) begin
        n.gen[{a[0], 3'h0} +: 8] = w;
      end else if (a[7:2] == R_GSEL[7:2]) begin
        for (int k = 0; k < 4; k++) begin
          n.gsel[{a[1:0], 2'(k)}] = w[2*k +: 2];
        end
      end else if (a[7:4] == R_GCFG[7:4]) begin
        n.gcfg[a[3:2]][a[1:0]] = w;
      end else if (a[7:4] == R_PWM[7:4]) begin
        n.pwm_sh[a[3:0]] = w;
      end else if (a[7:4] == R_IREF[7:4]) begin
        n.ir_sh[a[3:0]] = w;
      end else if (a[7:2] == R_ADDR[7:2]) begin
        n.addr[a[1:0]] = w[6:0];
      end
    end

    // Shadow settings reach the outputs only at the selected bus event
    commit = n.mode[M_ACK] ? bus_ack_i : bus_stop_i;
    if (commit) begin
      n.sel_act = n.sel_sh;
      n.pwm_act = n.pwm_sh;
      n.ir_act = n.ir_sh;
      n.grp_act = n.grp_sh;
      n.frq_act = n.frq_sh;
    end

    n.rdata = bus_i.rd ? rd_mux(s, a) : '0;

    if (soft_reset_call_i) begin
      n = RST_S;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    addr_hit_o = 1'b0;
    if (s.strap_cnt == STRAP_SETTLE) begin
      addr_hit_o = rx_addr_i == s.own;
      for (int k = 0; k < 4; k++) begin
        if (s.mode[M_EN + k] && rx_addr_i == s.addr[k]) begin
          addr_hit_o = 1'b1;
        end
      end
    end
  end

  assign rd_data_o = s.rdata;
  assign led_on_o = s.led;
  assign led_iref_o = s.iref;
  assign tsd_o = s.flt.otp;

endmodule : lpgc_core

// ===== testbench/lpgc_core_props.sv
module lpgc_core_props
  import lpgc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port and events
  input wire lpgc_bus_type bus_i,
  input wire logic [7:0] rd_data_o,
  input wire logic soft_reset_call_i,
  input wire logic [6:0] rx_addr_i,
  input wire logic addr_hit_o,
  // Pins and drive
  input wire logic oe_n_i,
  input wire logic overtemp_i,
  input wire logic [NCH-1:0] led_on_o,
  input wire logic [NCH-1:0][7:0] led_iref_o,
  input wire logic tsd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sr_ff;
  // A soft reset clears state one edge late, so that edge is masked too
  always_ff @(posedge clk_i) begin
    sr_ff <= soft_reset_call_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || soft_reset_call_i || sr_ff);

  rd_idle_a: assert property (
    !$past(bus_i.rd) |-> rd_data_o == 8'h00)
    else $error("read data outside its answer cycle");
  sr_off_a: assert property (disable iff (rst_i)
    soft_reset_call_i |=> (led_on_o == '0 && led_iref_o == '0)[*3])
    else $error("outputs live after soft reset");
  tsd_set_a: assert property (
    overtemp_i[*8] |-> tsd_o)
    else $error("thermal shutdown missing");
  tsd_clr_a: assert property (
    (!overtemp_i)[*8] |-> !tsd_o)
    else $error("thermal shutdown stuck");
  tsd_gate_a: assert property (
    tsd_o && $past(tsd_o) |-> led_on_o == '0)
    else $error("output on during shutdown");
  oe_gate_a: assert property (
    oe_n_i[*8] |-> led_on_o == '0)
    else $error("output on while gated");
  hit_boot_a: assert property (
    $fell(rst_i) |-> (!addr_hit_o)[*6])
    else $error("address answered before straps latched");
  hit_hold_a: assert property (
    $past(addr_hit_o) && $stable(rx_addr_i) && !$past(bus_i.wr)
    |-> addr_hit_o)
    else $error("address match dropped");
endmodule : lpgc_core_props

bind lpgc_core lpgc_core_props u_lpgc_core_props (
  .clk_i, .rst_i, .bus_i, .rd_data_o, .soft_reset_call_i, .rx_addr_i,
  .addr_hit_o, .oe_n_i, .overtemp_i, .led_on_o, .led_iref_o, .tsd_o
);

// ===== testbench/lpgc_host_model.sv
module lpgc_host_model (
  // Clock
  input wire logic clk_i,
  // Front end events
  output logic ack_o,
  output logic stop_o,
  output logic srst_o,
  output logic [6:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ack_o = 1'b0;
    stop_o = 1'b0;
    srst_o = 1'b0;
    addr_o = 7'h7F;
  end
  // Gap lets the host answer at once or after a stall
  task automatic pulse(input int kind, input int gap);
    repeat (gap + 1) @(posedge clk_i);
    case (kind)
      0: ack_o <= 1'b1;
      1: stop_o <= 1'b1;
      default: srst_o <= 1'b1;
    endcase
    @(posedge clk_i);
    ack_o <= 1'b0;
    stop_o <= 1'b0;
    srst_o <= 1'b0;
  endtask : pulse
  task automatic addr(input logic [6:0] a);
    @(posedge clk_i);
    addr_o <= a;
  endtask : addr
endmodule : lpgc_host_model

// ===== testbench/led_pwm_gradation_control_tb_top.sv
module led_pwm_gradation_control_tb_top;
  import lpgc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] BASE = 7'h01;
  // Arbitrary value
  localparam logic [6:0] SUB1_ID = 7'h5A;
  logic clk_i, rst_i, oe_n_i, overtemp_i, ack, stop, srst, hit, tsd;
  lpgc_bus_type bus;
  logic [7:0] rd_data;
  logic [6:0] rx_addr;
  logic [2:0] st [3];
  logic [NCH-1:0] open_i, short_i, led_on;
  logic [NCH-1:0][7:0] iref;
  int err_total, n_checks, own, cnt, d;
  int mdl [256];

  lpgc_core #(.HMS_TICKS(4), .ADDR_BASE(BASE), .SUB1_RST(SUB1_ID))
  u_lpgc_core (
    .clk_i, .rst_i, .bus_i(bus), .rd_data_o(rd_data), .bus_ack_i(ack),
    .bus_stop_i(stop), .soft_reset_call_i(srst), .rx_addr_i(rx_addr),
    .addr_hit_o(hit), .oe_n_i, .addr_strap_0_i(st[0]),
    .addr_strap_1_i(st[1]), .addr_strap_2_i(st[2]), .open_i, .short_i,
    .overtemp_i, .led_on_o(led_on), .led_iref_o(iref), .tsd_o(tsd));
  lpgc_host_model u_lpgc_host_model (.clk_i, .ack_o(ack), .stop_o(stop),
    .srst_o(srst), .addr_o(rx_addr));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got,
        exp);
    end
  endtask : cmp

  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == 8'h00) return 8'hF7;
    if (a inside {[8'h02:8'h07], [8'h20:8'h3F]}) return 8'hFF;
    if (a inside {[8'h40:8'h43]}) return 8'h7F;
    return 8'h00;
  endfunction : wmask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_i);
    bus.wr <= 1'b0;
    mdl[a] = int'(v & wmask(a));
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 cmp(rd_data, 8'(mdl[a]));
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic mdl_reset();
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8'h00] = int'(MODE_RST);
    mdl[8'h02] = int'(GRP_RST);
    mdl[8'h40] = int'(ADDR_GRP_RST);
    mdl[8'h41] = int'(SUB1_ID);
    mdl[8'h42] = int'(ADDR_SUB2_RST);
    mdl[8'h43] = int'(ADDR_SUB3_RST);
    own = int'(BASE) + 25 * st[2] + 5 * st[1] + st[0];
  endtask : mdl_reset

  // A match is the strapped address or any enabled programmable one
  task automatic hit_check(input logic [6:0] a);
    logic h;
    h = int'(a) == own;
    for (int i = 0; i < 4; i++) begin
      h |= mdl[0][4+i] && int'(a) == mdl[64+i];
    end
    u_lpgc_host_model.addr(a);
    #1 cmp({7'h00, hit}, {7'h00, h});
  endtask : hit_check

  task automatic count_on(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_i);
      cnt += int'(led_on[0]);
    end
  endtask : count_on

  // Group 0 ramps up in steps of 16 to 0x80, then ends as a single shot
  task automatic grad_run(input bit expc);
    int mx, bad, v;
    mx = 0;
    bad = 0;
    wr(8'h09, 8'h01);
    repeat (3000) begin
      @(posedge clk_i);
      #1;
      v = int'(iref[0]);
      if (v > mx) mx = v;
      bad++;
      for (int k = 0; k <= 8; k++) begin
        if (v == (expc ? k * k : 16 * k)) bad--;
      end
    end
    cmp(8'(mx), expc ? 8'h40 : 8'h80);
    cmp(8'(bad), 8'h00);
    rd(8'h09);
  endtask : grad_run

  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    stop_test();
  end

  initial begin
    bus = '0;
    oe_n_i = 1'b0;
    overtemp_i = 1'b0;
    open_i = '0;
    short_i = '0;
    rst_i = 1'b1;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'hE10F));
    foreach (st[i]) st[i] = 3'($urandom_range(4));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl_reset();
    settle(10);
    rd(8'h00);
    rd(8'h02);
    rd(8'h20);
    for (int a = 64; a < 68; a++) rd(8'(a));
    wr(8'h01, 8'hFF);
    rd(8'h01);
    rd(8'h80);
    hit_check(7'(own));
    hit_check(7'h60);
    hit_check(SUB1_ID);
    hit_check(7'h62);
    wr(8'h00, 8'h70);
    hit_check(7'h62);
    wr(8'h20, 8'hFF);
    wr(8'h30, 8'hA5);
    wr(8'h04, 8'h06);
    settle(40);
    cmp({7'h00, led_on[0]}, 8'h00);
    u_lpgc_host_model.pulse(1, 3);
    settle(40);
    cmp({6'h00, led_on[1:0]}, 8'h03);
    cmp(iref[0], 8'hA5);
    rd(8'h04);
    @(posedge clk_i) oe_n_i <= 1'b1;
    settle(12);
    cmp({6'h00, led_on[1:0]}, 8'h00);
    @(posedge clk_i) oe_n_i <= 1'b0;
    settle(12);
    cmp({6'h00, led_on[1:0]}, 8'h03);
    @(posedge clk_i) overtemp_i <= 1'b1;
    settle(12);
    cmp({7'h00, |led_on}, 8'h00);
    mdl[1] = 1;
    rd(8'h01);
    @(posedge clk_i) overtemp_i <= 1'b0;
    settle(12);
    mdl[1] = 0;
    cmp({7'h00, tsd}, 8'h00);
    @(posedge clk_i) open_i[1] <= 1'b1;
    settle(20);
    mdl[8'h44] = 2;
    rd(8'h44);
    @(posedge clk_i) open_i[1] <= 1'b0;
    settle(12);
    wr(8'h00, 8'h79);
    mdl[8'h44] = 0;
    rd(8'h44);
    rd(8'h00);
    d = $urandom_range(254, 1);
    wr(8'h20, 8'(d));
    settle(40);
    cmp({7'h00, led_on[0]}, 8'h01);
    u_lpgc_host_model.pulse(0, 0);
    settle(20);
    // One whole frame of the channel PWM at the 250 MHz clock
    count_on(8000);
    cmp({7'h00, 1'(cnt > d * 8000 / 256 - 100 &&
      cnt < d * 8000 / 256 + 100)}, 8'h01);
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h07);
    u_lpgc_host_model.pulse(0, 2);
    settle(40);
    count_on(600);
    cmp(8'(cnt), 8'h00);
    hit_check(7'(own));
    @(posedge clk_i) st[0] <= (st[0] == 3'h4) ? 3'h0 : st[0] + 3'h1;
    settle(12);
    cmp({7'h00, hit}, 8'h01);
    wr(8'h0A, 8'h01);
    wr(8'h10, 8'h8F);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h80);
    grad_run(1'b0);
    wr(8'h00, 8'h75);
    grad_run(1'b1);
    u_lpgc_host_model.pulse(2, 0);
    mdl_reset();
    settle(12);
    cmp({7'h00, |led_on}, 8'h00);
    rd(8'h00);
    rd(8'h20);
    rd(8'h02);
    hit_check(7'(own));
    stop_test();
  end
endmodule : led_pwm_gradation_control_tb_top
